// *** rtl/uvx_consts.svh ***
// Constants for the user-variable / X-register execution unit
`ifndef UVX_CONSTS_SVH
`define UVX_CONSTS_SVH

`define UVX_INSTR_VAR_FROM_X 8'h2B
`define UVX_INSTR_X_FROM_VAR 8'h2C
`define UVX_STATUS_OK 8'h64
`define UVX_STATUS_BAD_CSUM 8'h01
`define UVX_STATUS_BAD_INSTR 8'h02
`define UVX_STATUS_BAD_TYPE 8'h03
`define UVX_MODULE_ADDR 8'h01
`define UVX_HOST_ADDR 8'h02
`define UVX_LAST_BYTE 4'h8
`define UVX_LAST_TYPE 8'h0B
`define UVX_BYTE_ADDR 0
`define UVX_BYTE_INSTR 1
`define UVX_BYTE_TYPE 2
`define UVX_BYTE_BANK 3
`define UVX_BYTE_CSUM 8

`endif

// *** rtl/uvx_pkg.sv ***
// Types for the user-variable / X-register execution unit
package uvx_pkg;

  typedef enum logic [2:0] {
    UVX_RX = 3'b001,
    UVX_EXEC = 3'b010,
    UVX_TX = 3'b100
  } uvx_state_e;

  typedef enum logic [3:0] {
    UVX_OP_ADD = 4'h0,
    UVX_OP_SUB = 4'h1,
    UVX_OP_MUL = 4'h2,
    UVX_OP_DIV = 4'h3,
    UVX_OP_MOD = 4'h4,
    UVX_OP_AND = 4'h5,
    UVX_OP_OR = 4'h6,
    UVX_OP_XOR = 4'h7,
    UVX_OP_NOT = 4'h8,
    UVX_OP_LOAD = 4'h9,
    UVX_OP_SWAP = 4'hA,
    UVX_OP_COMP = 4'hB
  } uvx_op_e;

  typedef logic [8:0][7:0] uvx_frame_t;

  typedef struct packed {
    uvx_state_e st;
    logic [3:0] cnt;
    uvx_frame_t frame;
    uvx_frame_t reply;
    logic [31:0] xreg;
    logic cmp_eq;
    logic cmp_lt;
    logic rx_ready;
    logic tx_valid;
    logic [7:0] tx_byte;
  } uvx_state_s;

  function automatic logic [7:0] uvx_sum8(input uvx_frame_t f);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < 8; i++) begin
      s = s + f[i];
    end
    return s;
  endfunction : uvx_sum8

endpackage : uvx_pkg

// *** rtl/uvx_alu_if.sv ***
// Operand and result bundle between the frame engine and the arithmetic unit
interface uvx_alu_if;
  import uvx_pkg::*;
  uvx_op_e op;
  logic signed [31:0] a;
  logic signed [31:0] b;
  logic signed [31:0] res;
  logic cmp_eq;
  logic cmp_lt;
  logic div_zero;
  modport alu (input op, input a, input b, output res, output cmp_eq, output cmp_lt, output div_zero);
  modport user (output op, output a, output b, input res, input cmp_eq, input cmp_lt, input div_zero);
endinterface : uvx_alu_if

// *** rtl/uvx_alu.sv ***
// Combinational arithmetic unit: destination a combined with source b
module uvx_alu (
  uvx_alu_if.alu io
);
  import uvx_pkg::*;

  always_comb begin
    io.res = io.a;
    io.div_zero = 1'b0;
    unique case (io.op)
      UVX_OP_ADD: io.res = io.a + io.b;
      UVX_OP_SUB: io.res = io.a - io.b;
      UVX_OP_MUL: io.res = io.a * io.b;
      UVX_OP_DIV: begin
        // Divide by zero leaves destination unchanged
        io.div_zero = (io.b == 32'sh0);
        io.res = io.div_zero ? io.a : io.a / io.b;
      end
      UVX_OP_MOD: begin
        io.div_zero = (io.b == 32'sh0);
        io.res = io.div_zero ? io.a : io.a % io.b;
      end
      UVX_OP_AND: io.res = io.a & io.b;
      UVX_OP_OR: io.res = io.a | io.b;
      UVX_OP_XOR: io.res = io.a ^ io.b;
      UVX_OP_NOT: io.res = ~io.b;
      UVX_OP_LOAD: io.res = io.b;
      UVX_OP_SWAP: io.res = io.b;
      UVX_OP_COMP: io.res = io.a;
      default: io.res = io.a;
    endcase
    io.cmp_eq = (io.a == io.b);
    io.cmp_lt = (io.a < io.b);
  end

endmodule : uvx_alu

// *** rtl/uvx_exec.sv ***
// Frame engine executing the variable-from-X and X-from-variable instructions
// Function
// - Code 43: variable op X into variable
// - Code 44: X op variable into X
// - Bank byte is variable index; type selects op
// - Var target types 0-7: add..xor with X
// - Var target type 8: inverted X
// - Var target type 9: copy X
// - Type 10 swaps variable and X
// - Type 11 compares destination with source
// - X target types 0,1: add, subtract variable
// - X target types 2-4: mul, div, mod
// - X target types 5-7: and, or, xor
// - X target type 8: inverted variable
// - X target type 9: copy variable
// - Direct command answers status 100
// - Reply: host, addr, status, instr, value, sum
`include "uvx_consts.svh"

module uvx_exec (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  output logic rx_ready,
  output logic tx_valid,
  output logic [7:0] tx_byte,
  input wire logic tx_ready,
  output logic [31:0] xreg_value,
  output logic cmp_eq,
  output logic cmp_lt
);
  import uvx_pkg::*;

  // Whole engine state in one register
  uvx_state_s s_q;
  uvx_state_s s_d;
  logic [31:0] var_mem [0:255];
  logic var_we;
  logic [31:0] var_wdata;
  logic [31:0] var_rd;
  logic is_var_target;
  logic op_ok;
  uvx_frame_t reply_v;
  logic [7:0] status_v;
  logic [31:0] value_v;

  logic [7:0] fr_addr;
  logic [7:0] fr_instr;
  logic [7:0] fr_type;
  logic [7:0] fr_bank;
  logic [3:0] cnt_nx;
  logic last_byte;
  logic rx_take;
  logic tx_take;
  logic addr_hit;
  logic csum_ok;
  logic instr_ok;
  logic is_swap;
  logic is_comp;

  uvx_alu_if alu_io ();

  uvx_alu u_alu (
    .io(alu_io.alu)
  );

  // Fields of the request frame under execution
  assign fr_addr = s_q.frame[`UVX_BYTE_ADDR];
  assign fr_instr = s_q.frame[`UVX_BYTE_INSTR];
  assign fr_type = s_q.frame[`UVX_BYTE_TYPE];
  assign fr_bank = s_q.frame[`UVX_BYTE_BANK];
  assign cnt_nx = s_q.cnt + 4'h1;
  assign last_byte = (s_q.cnt == `UVX_LAST_BYTE);
  assign rx_take = rx_valid && s_q.rx_ready;
  assign tx_take = tx_ready && s_q.tx_valid;

  // Checksum tested after the address but before the code, so that a corrupt code is never trusted
  assign addr_hit = (fr_addr == `UVX_MODULE_ADDR);
  assign csum_ok = (uvx_sum8(s_q.frame) == s_q.frame[`UVX_BYTE_CSUM]);
  assign instr_ok = (fr_instr == `UVX_INSTR_VAR_FROM_X) || (fr_instr == `UVX_INSTR_X_FROM_VAR);
  assign op_ok = (fr_type <= `UVX_LAST_TYPE);

  // Destination operand on a, source operand on b
  assign var_rd = var_mem[fr_bank];
  assign is_var_target = (fr_instr == `UVX_INSTR_VAR_FROM_X);
  assign alu_io.op = uvx_op_e'(fr_type[3:0]);
  assign alu_io.a = is_var_target ? var_rd : s_q.xreg;
  assign alu_io.b = is_var_target ? s_q.xreg : var_rd;
  assign is_swap = (alu_io.op == UVX_OP_SWAP);
  assign is_comp = (alu_io.op == UVX_OP_COMP);

  always_comb begin
    s_d = s_q;
    var_we = 1'b0;
    var_wdata = alu_io.res;
    reply_v = s_q.reply;
    status_v = `UVX_STATUS_OK;
    value_v = alu_io.res;
    unique case (s_q.st)
      UVX_RX: begin
        // Byte n of the request lands in frame slot n
        if (rx_take) begin
          s_d.frame[s_q.cnt] = rx_byte;
          if (last_byte) begin
            s_d.st = UVX_EXEC;
            s_d.rx_ready = 1'b0;
            s_d.cnt = 4'h0;
          end else begin
            s_d.cnt = s_q.cnt + 4'h1;
          end
        end
      end
      UVX_EXEC: begin
        if (!addr_hit) begin
          // Frames for other modules are dropped silently
          s_d.st = UVX_RX;
          s_d.rx_ready = 1'b1;
        end else begin
          // A rejected frame answers value 0 and changes nothing
          if (!csum_ok) begin
            status_v = `UVX_STATUS_BAD_CSUM;
            value_v = 32'h0;
          end else if (!instr_ok) begin
            status_v = `UVX_STATUS_BAD_INSTR;
            value_v = 32'h0;
          end else if (!op_ok) begin
            status_v = `UVX_STATUS_BAD_TYPE;
            value_v = 32'h0;
          end else if (is_comp) begin
            s_d.cmp_eq = alu_io.cmp_eq;
            s_d.cmp_lt = alu_io.cmp_lt;
            value_v = alu_io.a;
          end else if (is_var_target) begin
            // Divide by zero keeps the destination as it was
            var_we = !alu_io.div_zero;
            if (is_swap) begin
              s_d.xreg = var_rd;
            end
          end else begin
            if (!alu_io.div_zero) begin
              s_d.xreg = alu_io.res;
            end
            if (is_swap) begin
              var_we = 1'b1;
              var_wdata = s_q.xreg;
            end
          end
          reply_v[0] = `UVX_HOST_ADDR;
          reply_v[1] = `UVX_MODULE_ADDR;
          reply_v[2] = status_v;
          reply_v[3] = fr_instr;
          reply_v[4] = value_v[31:24];
          reply_v[5] = value_v[23:16];
          reply_v[6] = value_v[15:8];
          reply_v[7] = value_v[7:0];
          reply_v[8] = uvx_sum8(reply_v);
          s_d.reply = reply_v;
          s_d.st = UVX_TX;
          s_d.tx_valid = 1'b1;
          s_d.tx_byte = reply_v[0];
          s_d.cnt = 4'h0;
        end
      end
      UVX_TX: begin
        // Next reply byte follows each accept
        if (tx_take) begin
          if (last_byte) begin
            s_d.st = UVX_RX;
            s_d.tx_valid = 1'b0;
            s_d.rx_ready = 1'b1;
            s_d.cnt = 4'h0;
          end else begin
            s_d.cnt = cnt_nx;
            s_d.tx_byte = s_q.reply[cnt_nx];
          end
        end
      end
      default: begin
        s_d.st = UVX_RX;
        s_d.rx_ready = 1'b1;
        s_d.tx_valid = 1'b0;
        s_d.cnt = 4'h0;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q.st <= UVX_RX;
      s_q.cnt <= 4'h0;
      s_q.frame <= '0;
      s_q.reply <= '0;
      s_q.xreg <= 32'h0;
      s_q.cmp_eq <= 1'b0;
      s_q.cmp_lt <= 1'b0;
      s_q.rx_ready <= 1'b1;
      s_q.tx_valid <= 1'b0;
      s_q.tx_byte <= 8'h00;
    end else begin
      s_q <= s_d;
    end
  end

  // Variable store has no reset
  always_ff @(posedge sys_clk) begin
    if (var_we) begin
      var_mem[fr_bank] <= var_wdata;
    end
  end

  // Top outputs straight from the state register
  assign rx_ready = s_q.rx_ready;
  assign tx_valid = s_q.tx_valid;
  assign tx_byte = s_q.tx_byte;
  assign xreg_value = s_q.xreg;
  assign cmp_eq = s_q.cmp_eq;
  assign cmp_lt = s_q.cmp_lt;

endmodule : uvx_exec

// *** sim/uvx_exec_asserts.sv ***
// Port checker for the execution unit
module uvx_exec_asserts (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  input wire logic tx_ready,
  input wire logic [31:0] xreg_value,
  input wire logic cmp_eq,
  input wire logic cmp_lt
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] n_q;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Reply bytes taken in this answer
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) n_q <= 4'h0;
    else if (rx_ready) n_q <= 4'h0;
    else if (tx_valid && tx_ready) n_q <= n_q + 4'h1;
  end
  sequence s_start;
    $rose(tx_valid) && tx_ready;
  endsequence
  chk_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
    else $error("reply byte dropped");
  chk_host_first: assert property ($rose(tx_valid) |-> tx_byte == 8'h02)
    else $error("bad host byte");
  chk_target_next: assert property (s_start |=> tx_byte == 8'h01)
    else $error("bad target byte");
  chk_reply_len: assert property ($fell(tx_valid) |-> n_q == 4'h9)
    else $error("bad reply length");
  chk_rx_closed: assert property (tx_valid |-> !rx_ready)
    else $error("request open in reply");
  chk_reply_start: assert property ($fell(rx_ready) |-> ##[1:2] (tx_valid || rx_ready))
    else $error("late reply");
  chk_xreg_idle: assert property (rx_ready |=> $stable(xreg_value))
    else $error("x changed idle");
  chk_flag_excl: assert property (!(cmp_eq && cmp_lt))
    else $error("flags clash");
endmodule : uvx_exec_asserts
bind uvx_exec uvx_exec_asserts i_uvx_exec_asserts (.*);

// *** sim/uvx_host.sv ***
// Host model sending request frames and taking replies
module uvx_host (
  input wire logic sys_clk,
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  output logic rx_valid,
  output logic [7:0] rx_byte,
  output logic tx_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  import uvx_pkg::*;
  logic [7:0] rep [$];
  int k = 0;
  initial {rx_valid, rx_byte, tx_ready} = '0;
  // Stalls of up to three cycles
  always @(posedge sys_clk) begin
    if (tx_valid && tx_ready) rep.push_back(tx_byte);
    k++;
    #1 tx_ready <= (k % 7) > 2;
  end
  task automatic send(input uvx_frame_t f);
    for (int i = 0; i < 9; i++) begin
      rx_valid <= 1'b1;
      rx_byte <= f[i];
      do @(posedge sys_clk); while (!rx_ready);
      #1;
    end
    rx_valid <= 1'b0;
    rx_byte <= ~rx_byte;
  endtask : send
endmodule : uvx_host

// *** sim/user_var_xreg_alu_tb_top.sv ***
// Random and corner runs of the execution unit
module user_var_xreg_alu_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import uvx_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic rx_valid, rx_ready, tx_valid, tx_ready, cmp_eq, cmp_lt, fe, fl;
  logic [7:0] rx_byte, tx_byte;
  logic [31:0] xreg_value, mx, r;
  logic [31:0] rs = 32'h501C;
  logic [31:0] mv [256];
  uvx_frame_t fo;
  int n_errors = 0;
  int cmp_count = 0;
  always #2.5 sys_clk = ~sys_clk;
  uvx_exec i_uvx_exec (.*);
  uvx_host i_uvx_host (.*);
  function automatic logic [31:0] nxt();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction : nxt
  function automatic logic [31:0] alu(input logic [3:0] t, input logic signed [31:0] a, input logic signed [31:0] b);
    case (t)
      4'h0: return a + b;
      4'h1: return a - b;
      4'h2: return a * b;
      4'h3: return (b == 0) ? a : a / b;
      4'h4: return (b == 0) ? a : a % b;
      4'h5: return a & b;
      4'h6: return a | b;
      4'h7: return a ^ b;
      4'h8: return ~b;
      4'h9, 4'hA: return b;
      default: return a;
    endcase
  endfunction : alu
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic run(input logic [7:0] ins, input logic [7:0] ty, input logic [7:0] bk, input logic bad);
    uvx_frame_t f, e;
    logic [31:0] d, s, v, w;
    logic [7:0] st;
    logic ok;
    d = (ins == 8'h2B) ? mv[bk] : mx;
    s = (ins == 8'h2B) ? mx : mv[bk];
    v = alu(ty[3:0], d, s);
    st = bad ? 8'h01 : (ins != 8'h2B && ins != 8'h2C) ? 8'h02 : (ty > 8'h0B) ? 8'h03 : 8'h64;
    ok = st == 8'h64;
    w = ok ? v : 32'h0;
    f = {8'h00, nxt(), bk, ty, ins, 8'h01};
    e = {8'h00, w[7:0], w[15:8], w[23:16], w[31:24], ins, st, 8'h01, 8'h02};
    for (int i = 0; i < 8; i++) begin
      f[8] += f[i];
      e[8] += e[i];
    end
    f[8] += bad;
    if (ok && ty == 8'h0B) {fe, fl} = {d == s, $signed(d) < $signed(s)};
    else if (ok && ins == 8'h2B) {mv[bk], mx} = {v, ty == 8'h0A ? d : mx};
    else if (ok) {mx, mv[bk]} = {v, ty == 8'h0A ? d : mv[bk]};
    i_uvx_host.send(f);
    for (int i = 0; i < 300 && i_uvx_host.rep.size() < 9; i++) @(posedge sys_clk);
    #1;
    for (int i = 0; i < 9; i++) chk("reply", i_uvx_host.rep[i], e[i]);
    chk("xreg", xreg_value, mx);
    chk("flags", {cmp_eq, cmp_lt}, {fe, fl});
    i_uvx_host.rep.delete();
  endtask : run
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim
  // Ten times the expected run
  initial begin
    #200000;
    n_errors++;
    end_sim();
  end
  initial begin
    {mx, fe, fl} = '0;
    repeat (4) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    chk("reset", {rx_ready, tx_valid, cmp_eq, cmp_lt}, 4'h8);
    chk("reset xreg", xreg_value, 32'h0);
    for (int i = 0; i < 8; i++) run(8'h2B, 8'h09, (i == 7) ? 8'hFF : 8'(i), 1'b0);
    run(8'h2C, 8'h08, 8'h00, 1'b0);
    $display("setup done");
    run(8'h2B, 8'h09, 8'h1B, 1'b0);
    run(8'h2C, 8'h01, 8'h1B, 1'b0);
    run(8'h2B, 8'h01, 8'h1B, 1'b0);
    fo = {8'h00, 32'h0, 8'h00, 8'h09, 8'h2B, 8'h05};
    fo[8] = 8'h39;
    i_uvx_host.send(fo);
    repeat (30) @(posedge sys_clk);
    #1;
    chk("foreign reply", i_uvx_host.rep.size(), 32'h0);
    chk("foreign xreg", xreg_value, mx);
    chk("foreign open", rx_ready, 1'b1);
    $display("corner done");
    for (int i = 0; i < 150; i++) begin
      r = nxt();
      run(r[3:0] == 4'h0 ? 8'h2D : r[4] ? 8'h2B : 8'h2C, 8'(r[11:8] % 13), r[14:12] == 3'h7 ? 8'hFF : 8'(r[14:12]),
        r[19:16] == 4'h0);
    end
    $display("random done");
    end_sim();
  end
endmodule : user_var_xreg_alu_tb_top
